// file: verilog/pmfc_pkg.sv
// Constants, frame layout and mode type of the power-mode and fallback
// controller. Assumes a 250 MHz core clock and 16-bit serial frames.
// How it works
// RULE1 - At power-up all registers take defaults and the device sleeps.
// RULE2 - A frame with the wake bit set moves sleep to operation.
// RULE3 - A frame with the standby bit set returns operation to sleep.
// RULE4 - Host waits the wake settle time, at most 200 us, after waking.
// RULE5 - Frames arriving during the wake settle interval are discarded.
// RULE6 - Low battery supply asserts the undervoltage reset.
// RULE7 - Shift register and serial out work whenever logic supply is good.
// RULE8 - Entering sleep resets the bank; commands and the fallback input enter or leave sleep.
// RULE9 - High fallback clears registers and routes inputs to channels 4, 5.
// RULE10 - In sleep a high fallback input wakes the device.
// RULE11 - When fallback ends the device always goes to sleep.
// RULE12 - Any reset switches all channels off and restores register defaults.
// RULE13 - After any reset the transfer error flag is set and device sleeps.
// RULE14 - In battery reset with logic up, reads give status with error flag.
// RULE15 - Undervoltage reset is released only when both supplies are good.
// RULE16 - The reset command bit clears register bank and diagnosis at once.
// RULE17 - In fallback status stays readable but every command is rejected.
// RULE18 - Switches need battery; bank reset without battery or in fallback.
// RULE19 - Each undervoltage reset takes effect within 1 us of the drop.
package pmfc_pkg;
  localparam int          CLK_MHZ          = 250;
  localparam int          WAKE_SETTLE_US   = 200;
  localparam int          WAKE_SETTLE_CYC  = WAKE_SETTLE_US * CLK_MHZ;
  localparam int          UV_DELAY_US      = 1;
  localparam int          UV_DELAY_CYC     = UV_DELAY_US * CLK_MHZ;
  localparam int          FRAME_BITS       = 16;
  localparam int          NUM_CH           = 8;
  localparam int          FB_CH_A          = 4;
  localparam int          FB_CH_B          = 5;
  // Frame opcode in bits 15:14, command bits in the low byte.
  localparam int          OPC_HI           = 15;
  localparam int          OPC_LO           = 14;
  localparam logic [1:0]  OPC_READ         = 2'h0;
  localparam logic [1:0]  OPC_WRITE_BANK   = 2'h2;
  localparam logic [1:0]  OPC_COMMAND      = 2'h3;
  localparam int          CMD_WAKE_POS     = 0;
  localparam int          CMD_STANDBY_POS  = 1;
  localparam int          CMD_RESET_POS    = 2;
  // Status frame layout.
  localparam int          ST_TER_POS       = 15;
  localparam int          ST_FB_POS        = 14;
  localparam int          ST_OP_POS        = 13;
  localparam int          ST_WAKING_POS    = 12;
  localparam logic [7:0]  BANK_RESET       = 8'h00;
  localparam logic [7:0]  DIAG_RESET       = 8'h00;
  localparam logic        TER_RESET        = 1'b1;
  localparam logic [15:0] TX_RESET         = 16'h8000;
  localparam logic [15:0] SETTLE_RESET     = 16'h0000;
  typedef enum logic [1:0] {
    PMFC_SLEEP,
    PMFC_WAKING,
    PMFC_OPERATE,
    PMFC_FALLBACK
  } pmfc_mode_e;
endpackage

// file: verilog/pmfc_sync.sv
// Two-flop synchroniser bank for pins and link-domain levels.
// Assumes each bit is an independent level; the first stage feeds only
// the second.
`timescale 1ns/10ps
module pmfc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,   // Core clock.
  input  wire logic         rst,   // Asynchronous reset, active high.
  input  wire logic         ce,    // Clock enable.
  input  wire logic [W-1:0] d,     // Asynchronous levels.
  output logic      [W-1:0] q      // Synchronised levels.
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // pmfc_sync

// file: verilog/pmfc_spi_link.sv
// Serial shift logic on the serial clock; runs from the logic supply only.
// Assumes mode with data sampled on the rising edge, MSB first, and a
// reply word that stays still while chip select is low.
`timescale 1ns/10ps
module pmfc_spi_link
  import pmfc_pkg::*;
(
  input  wire logic        sclk,       // Serial clock from the host.
  input  wire logic        rst,        // Asynchronous reset, active high.
  input  wire logic        logic_ok,   // Logic supply in range.
  input  wire logic        cs_n,       // Chip select, active low.
  input  wire logic        si,         // Serial data in.
  input  wire logic [15:0] tx_word,    // Reply word from the core.
  output logic             so,         // Serial data out.
  output logic             so_en,      // Serial out drive enable.
  output logic      [15:0] rx_word,    // Last whole 16-bit word.
  output logic             rx_toggle   // Toggles per whole word.
);
  logic        frame_rst;
  logic        started;
  logic [3:0]  bit_cnt;
  logic [15:0] shift;
  wire  [15:0] next_shift = started ? {shift[14:0], si} : {tx_word[14:0], si};

  // Shift path depends only on the logic supply, never on the battery. [RULE7]
  assign frame_rst = rst | cs_n | ~logic_ok;
  assign so        = started ? shift[15] : tx_word[15];
  assign so_en     = ~cs_n & logic_ok;

  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      started <= 1'b0;
      bit_cnt <= 4'h0;
      shift   <= 16'h0000;
    end else begin
      started <= 1'b1;
      bit_cnt <= bit_cnt + 4'h1;
      shift   <= next_shift;
    end
  end

  // Every 16 bits a word is published; the core uses the last one.
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      rx_word   <= 16'h0000;
      rx_toggle <= 1'b0;
    end else if (logic_ok && !cs_n && bit_cnt == 4'hf) begin
      rx_word   <= next_shift;
      rx_toggle <= ~rx_toggle;
    end
  end
endmodule // pmfc_spi_link

// file: verilog/pmfc_ctrl.sv
// Power-mode and fallback controller: modes, resets, register bank,
// diagnosis flags and channel drive, with the serial link on its own clock.
// Assumes supply-good and fallback levels come straight from pins.
`timescale 1ns/10ps
module pmfc_ctrl
  import pmfc_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_SETTLE_CYC
) (
  input  wire logic              clk,           // Core clock, 250 MHz.
  input  wire logic              rst,           // Async reset, active high.
  input  wire logic              ce,            // Clock enable.
  input  wire logic              battery_supply,// Battery supply good pin.
  input  wire logic              logic_supply,  // Logic supply good pin.
  input  wire logic              fallback_drive_input, // Fallback pin.
  input  wire logic [1:0]        in_pin,        // Direct input pins.
  input  wire logic [NUM_CH-1:0] diag_fault,    // Raw channel faults.
  input  wire logic              spi_sclk,      // Serial clock.
  input  wire logic              spi_cs_n,      // Chip select, active low.
  input  wire logic              spi_si,        // Serial data in.
  output logic                   spi_so,        // Serial data out.
  output logic                   spi_so_en,     // Serial out enable.
  output logic      [NUM_CH-1:0] ch_on,         // Channel drive.
  output logic                   transfer_error_flag, // Error flag.
  output logic                   mode_operate,  // Operation mode.
  output logic                   mode_fallback, // Fallback mode.
  output logic                   uv_reset       // Undervoltage reset.
);
  localparam int SYNC_W = 5 + 2 + NUM_CH;

  pmfc_mode_e        mode;
  pmfc_mode_e        next_mode;
  logic [15:0]       settle_cnt;
  logic [7:0]        bank;
  logic [7:0]        diag;
  logic [15:0]       tx_word;
  logic              rx_seen;
  logic              frame_pend;
  logic [15:0]       rx_word;
  logic              rx_toggle;
  logic [SYNC_W-1:0] sync_q;

  pmfc_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   ({rx_toggle, spi_cs_n, fallback_drive_input, logic_supply,
           battery_supply, in_pin, diag_fault}),
    .q   (sync_q)
  );

  pmfc_spi_link u_link (
    .sclk      (spi_sclk),
    .rst       (rst),
    .logic_ok  (logic_supply),
    .cs_n      (spi_cs_n),
    .si        (spi_si),
    .tx_word   (tx_word),
    .so        (spi_so),
    .so_en     (spi_so_en),
    .rx_word   (rx_word),
    .rx_toggle (rx_toggle)
  );

  wire             tog_s   = sync_q[SYNC_W-1];
  wire             cs_n_s  = sync_q[SYNC_W-2];
  wire             fb_s    = sync_q[SYNC_W-3];
  wire             lok_s   = sync_q[SYNC_W-4];
  wire             bok_s   = sync_q[SYNC_W-5];
  wire [1:0]       in_s    = sync_q[NUM_CH+1:NUM_CH];
  wire [NUM_CH-1:0] flt_s  = sync_q[NUM_CH-1:0];

  // Held while either supply is low; two core cycles is far under 1 us.
  wire uv_now   = ~bok_s | ~lok_s; // [RULE6] [RULE15] [RULE19]

  // A frame is acted on once chip select is back high.
  wire tog_edge = tog_s ^ rx_seen;
  wire frame_go = frame_pend & cs_n_s;
  wire [1:0] opc = rx_word[OPC_HI:OPC_LO];
  wire is_cmd   = frame_go & (opc == OPC_COMMAND);
  wire is_write = frame_go & (opc == OPC_WRITE_BANK);
  // Frames are ignored while settling or in fallback. [RULE5] [RULE17]
  wire accept   = ~uv_now & (mode == PMFC_SLEEP || mode == PMFC_OPERATE);
  wire cmd_rst  = accept & is_cmd & rx_word[CMD_RESET_POS];   // [RULE16]
  wire standby_command_bit  = accept & is_cmd & rx_word[CMD_STANDBY_POS];
  wire cmd_wake = accept & is_cmd & rx_word[CMD_WAKE_POS];
  wire wr_bank  = accept & is_write & (mode == PMFC_OPERATE);
  wire any_rst  = uv_now | cmd_rst;                        // [RULE12]
  wire settled  = settle_cnt == 16'(WAKE_CYCLES - 1);
  wire good_rx  = accept & frame_go & ~cmd_rst;

  always_comb begin
    next_mode = mode;
    unique case (mode)
      PMFC_SLEEP: begin
        if (fb_s)
          next_mode = PMFC_FALLBACK;                       // [RULE10]
        else if (cmd_wake)
          next_mode = PMFC_WAKING;                         // [RULE2]
      end
      PMFC_WAKING: begin
        if (fb_s)
          next_mode = PMFC_FALLBACK;
        else if (settled)
          next_mode = PMFC_OPERATE;
      end
      PMFC_OPERATE: begin
        if (fb_s)
          next_mode = PMFC_FALLBACK;                       // [RULE9]
        else if (standby_command_bit)
          next_mode = PMFC_SLEEP;                          // [RULE3] [RULE8]
      end
      PMFC_FALLBACK: begin
        if (!fb_s)
          next_mode = PMFC_SLEEP;                          // [RULE11]
      end
    endcase
    if (any_rst)
      next_mode = PMFC_SLEEP;                              // [RULE13]
  end

  // Bank is cleared whenever the device is not in operation. [RULE8] [RULE18]
  wire bank_clr = any_rst | (next_mode != PMFC_OPERATE);
  wire [7:0] next_bank = bank_clr ? BANK_RESET :
                         wr_bank ? rx_word[7:0] : bank;

  // Diagnosis only runs with battery present and fallback low. [RULE18]
  wire diag_on = bok_s & ~fb_s & (mode == PMFC_OPERATE);
  wire [7:0] next_diag = any_rst ? DIAG_RESET :
                         (diag | (diag_on ? flt_s : 8'h00));

  // Set wins over the clear by an accepted frame. [RULE13] [RULE14]
  wire next_ter = any_rst | (transfer_error_flag & ~good_rx);

  // Fallback routes the two inputs straight to channels 4 and 5. [RULE9]
  logic [NUM_CH-1:0] fb_drive;
  always_comb begin
    fb_drive          = '0;
    fb_drive[FB_CH_A] = in_s[0];
    fb_drive[FB_CH_B] = in_s[1];
  end
  wire [NUM_CH-1:0] next_ch =
    (any_rst | ~bok_s) ? '0 :                              // [RULE12] [RULE18]
    (next_mode == PMFC_FALLBACK) ? fb_drive :
    (next_mode == PMFC_OPERATE) ? next_bank : '0;

  wire [15:0] next_tx = {next_ter, next_mode == PMFC_FALLBACK,
                         next_mode == PMFC_OPERATE,
                         next_mode == PMFC_WAKING, 4'h0, next_diag};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode       <= PMFC_SLEEP;                            // [RULE1]
      settle_cnt <= SETTLE_RESET;
      rx_seen    <= 1'b0;
      frame_pend <= 1'b0;
    end else if (ce) begin
      mode       <= next_mode;
      settle_cnt <= (mode == PMFC_WAKING && !settled) ?
                    settle_cnt + 16'h0001 : SETTLE_RESET;
      rx_seen    <= tog_s;
      frame_pend <= tog_edge | (frame_pend & ~cs_n_s);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bank                <= BANK_RESET;                   // [RULE1]
      diag                <= DIAG_RESET;
      transfer_error_flag <= TER_RESET;
      ch_on               <= '0;
    end else if (ce) begin
      bank                <= next_bank;
      diag                <= next_diag;
      transfer_error_flag <= next_ter;
      ch_on               <= next_ch;
    end
  end

  // Reply word only changes while the link is idle. [RULE14]
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      tx_word <= TX_RESET;
    else if (ce && cs_n_s)
      tx_word <= next_tx;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_operate  <= 1'b0;
      mode_fallback <= 1'b0;
      uv_reset      <= 1'b1;
    end else if (ce) begin
      mode_operate  <= next_mode == PMFC_OPERATE;
      mode_fallback <= next_mode == PMFC_FALLBACK;
      uv_reset      <= uv_now;
    end
  end
endmodule // pmfc_ctrl

// file: test/pmfc_host_model.sv
// Host serial master model for the power-mode controller's link pins.
// Assumes the bench calls xfer with chip select idle and waits between.
`timescale 1ns/10ps
module pmfc_host_model (
  input  wire logic so,   // Serial data from the device.
  output logic      sclk, // Serial clock, still between frames.
  output logic      cs_n, // Chip select, active low.
  output logic      si    // Serial data to the device.
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b1;
  end
  // Reply bits are taken just before each rising edge, as the device
  // moves its output only after that edge.
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    cs_n = 1'b0;
    #12;
    for (int i = 15; i >= 0; i--) begin
      si = w[i];
      #6;
      r[i] = so;
      sclk = 1'b1;
      #6;
      sclk = 1'b0;
    end
    #6;
    cs_n = 1'b1;
    si   = ~si;
    #40;
  endtask
endmodule // pmfc_host_model

// file: test/pmfc_ctrl_monitor.sv
// Concurrent checks on the ports of the power-mode controller.
// Assumes it is bound into pmfc_ctrl and sees its ports only.
`timescale 1ns/10ps
module pmfc_ctrl_monitor (
  input wire logic       clk,                  // Core clock.
  input wire logic       rst,                  // Reset, active high.
  input wire logic       battery_supply,       // Battery good pin.
  input wire logic       logic_supply,         // Logic good pin.
  input wire logic       fallback_drive_input, // Fallback pin.
  input wire logic       spi_cs_n,             // Chip select.
  input wire logic       spi_so_en,            // Serial out enable.
  input wire logic [7:0] ch_on,                // Channel drive.
  input wire logic       transfer_error_flag,  // Error flag.
  input wire logic       mode_operate,         // Operation mode.
  input wire logic       mode_fallback,        // Fallback mode.
  input wire logic       uv_reset              // Undervoltage reset.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  uv_entry_a: assert property (
    $fell(battery_supply) || $fell(logic_supply) |-> ##[1:4] uv_reset)
    else $error("uv reset late");
  uv_effect_a: assert property (
    $rose(uv_reset) |-> ##[0:3] (ch_on == 8'h00 &&
    transfer_error_flag && !mode_operate))
    else $error("uv effect late");
  uv_hold_a: assert property (
    uv_reset && !(battery_supply && logic_supply) |=> uv_reset)
    else $error("uv released early");
  // The battery pin reaches the channel drive three samples later.
  uv_switch_a: assert property (
    !$past(battery_supply, 3) |-> ch_on == 8'h00)
    else $error("switch on without battery");
  fb_entry_a: assert property (
    $rose(fallback_drive_input) && !uv_reset && battery_supply &&
    logic_supply |-> ##[1:5] mode_fallback)
    else $error("fallback not entered");
  fb_route_a: assert property (
    mode_fallback && $past(mode_fallback, 2) |-> (ch_on & 8'hcf) == 8'h00)
    else $error("bad fallback channel");
  fb_exit_a: assert property (
    $fell(mode_fallback) |-> !mode_operate [*2])
    else $error("fallback exit not sleep");
  idle_off_a: assert property (
    !mode_operate && !mode_fallback && !$past(mode_operate) &&
    !$past(mode_fallback) |-> ch_on == 8'h00)
    else $error("channel on in sleep");
  so_drive_a: assert property (
    spi_so_en == (!spi_cs_n && logic_supply))
    else $error("serial out enable wrong");
  cover property ($rose(mode_operate));
  cover property ($rose(mode_fallback));
  cover property ($rose(uv_reset));
endmodule // pmfc_ctrl_monitor
bind pmfc_ctrl pmfc_ctrl_monitor u_mon (.clk, .rst, .battery_supply,
  .logic_supply, .fallback_drive_input, .spi_cs_n, .spi_so_en, .ch_on,
  .transfer_error_flag, .mode_operate, .mode_fallback, .uv_reset);

// file: test/tb_pmfc_ctrl.sv
// Self-checking bench for the power-mode and fallback controller.
// Assumes the host model drives the link and a short wake settle count.
`timescale 1ns/10ps
module tb_pmfc_ctrl;
  localparam int WAKE = 200;
  logic clk = 0, rst = 0, ce = 1, battery_supply = 1, logic_supply = 1;
  logic fallback_drive_input = 0;
  logic [1:0] in_pin = 0;
  logic [7:0] diag_fault = 0;
  wire spi_sclk, spi_cs_n, spi_si, spi_so, spi_so_en, transfer_error_flag;
  wire mode_operate, mode_fallback, uv_reset;
  wire [7:0] ch_on;
  logic [15:0] rep;
  int failures = 0, n_compared = 0;
  always #2 clk = ~clk;
  pmfc_ctrl #(.WAKE_CYCLES(WAKE)) uut (.clk, .rst, .ce, .battery_supply,
    .logic_supply, .fallback_drive_input, .in_pin, .diag_fault, .spi_sclk,
    .spi_cs_n, .spi_si, .spi_so, .spi_so_en, .ch_on, .transfer_error_flag,
    .mode_operate, .mode_fallback, .uv_reset);
  pmfc_host_model host (.so(spi_so), .sclk(spi_sclk), .cs_n(spi_cs_n),
    .si(spi_si));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task frame(input logic [15:0] w);
    host.xfer(w, rep);
    cyc(10);
  endtask
  task wake;
    frame(16'hc001);
    cyc(WAKE);
  endtask
  task results;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task t_boot;
    chk(ch_on, 8'h00);
    chk(transfer_error_flag, 1'b1);
    chk(mode_operate, 1'b0);
    chk(spi_so_en, 1'b0);
    frame(16'h0000);
    chk(rep[15], 1'b1);
  endtask
  task t_cmds;
    frame(16'hc001);
    frame(16'h80ff);
    cyc(WAKE);
    chk(mode_operate, 1'b1);
    chk(ch_on, 8'h00);
    chk(rep[13:12], 2'b01);
    frame(16'h80a5);
    chk(ch_on, 8'ha5);
    diag_fault <= 8'h04;
    cyc(6);
    diag_fault <= 8'h00;
    frame(16'h0000);
    chk(rep[7:0], 8'h04);
    // A fault seen only while the clock enable is low must not latch.
    ce <= 1'b0;
    diag_fault <= 8'h08;
    cyc(6);
    diag_fault <= 8'h00;
    cyc(4);
    ce <= 1'b1;
    frame(16'h0000);
    chk(rep[7:0], 8'h04);
    frame(16'hc004);
    chk(ch_on, 8'h00);
    chk({transfer_error_flag, mode_operate}, 2'b10);
    frame(16'h0000);
    chk(rep[7:0], 8'h00);
    wake();
    frame(16'h80ff);
    frame(16'hc002);
    chk({mode_operate, ch_on}, 9'h000);
  endtask
  task t_fb;
    in_pin <= 2'b01;
    fallback_drive_input <= 1'b1;
    cyc(8);
    chk({mode_fallback, ch_on}, 9'h110);
    frame(16'hc001);
    frame(16'h80ff);
    chk({mode_operate, ch_on}, 9'h010);
    chk(rep[14], 1'b1);
    in_pin <= 2'b10;
    cyc(6);
    chk(ch_on, 8'h20);
    fallback_drive_input <= 1'b0;
    cyc(8);
    chk({mode_fallback, ch_on}, 9'h000);
    wake();
    fallback_drive_input <= 1'b1;
    cyc(8);
    fallback_drive_input <= 1'b0;
    cyc(8);
    chk(mode_operate, 1'b0);
  endtask
  task t_uv;
    wake();
    frame(16'h80ff);
    battery_supply <= 1'b0;
    cyc(6);
    chk({uv_reset, ch_on}, 9'h100);
    chk(transfer_error_flag, 1'b1);
    frame(16'h0000);
    chk(rep[15], 1'b1);
    logic_supply <= 1'b0;
    cyc(2);
    battery_supply <= 1'b1;
    cyc(8);
    chk(uv_reset, 1'b1);
    logic_supply <= 1'b1;
    cyc(8);
    chk({uv_reset, mode_operate, transfer_error_flag}, 3'b001);
  endtask
  initial begin
    #100000;
    failures++;
    results();
  end
  initial begin
    // A real rising edge on reset clears the link-domain flops as well.
    rst <= 1'b1;
    cyc(6);
    rst <= 1'b0;
    cyc(6);
    t_boot();
    t_cmds();
    t_fb();
    t_uv();
    results();
  end
endmodule // tb_pmfc_ctrl
